// ### src/lsdpm_defs.svh
// Constants for the strobe dimming and pump mode controller.
// Assumes a 25 MHz system clock; times are in ns, counts derived here.
// How it works
// RL1: Main rising edge decrements 5-bit counter.
// RL2: Camera rising edge decrements 3-bit counter.
// RL3: Counters stop at one LSB.
// RL4: First strobe full scale; 31/7 to minimum.
// RL5: Host leaves strobe high after last edge.
// RL6: High for 150us loads counter into DAC.
// RL7: Held low zeroes current, clears counter.
// RL8: Resume within 150us keeps count, else reset.
// RL9: Both low past 150us enters shutdown.
// RL10: Leaving shutdown adds 100us enable delay.
// RL11: Pump starts 1x after reset or shutdown.
// RL12: Dropout steps 1x to 1.5x to 2x.
// RL13: Camera falling edge or shutdown gives 1x.
// RL14: Two-phase non-overlapping 800kHz pump clock; code runs it at 781kHz.
// RL15: 2x charges capacitors on alternate phases.
// RL16: 1.5x series charge, parallel stack discharge.
// RL17: Fourth main output copies main code.
// RL18: Dropout mode step after 0.4ms.
// RL19: Host pulses at least 200ns.
// RL20: Delays counted in cycles, restart on edges.
// RL21: DAC code held apart from counter.
`ifndef LSDPM_DEFS_SVH
`define LSDPM_DEFS_SVH
`define LSDPM_CLK_NS      40
`define LSDPM_SETTLE_NS   150000
`define LSDPM_SETTLE_CYC  (`LSDPM_SETTLE_NS / `LSDPM_CLK_NS)
`define LSDPM_BGAP_NS     100000
`define LSDPM_BGAP_CYC    (`LSDPM_BGAP_NS / `LSDPM_CLK_NS)
`define LSDPM_MODE_NS     400000
`define LSDPM_MODE_CYC    (`LSDPM_MODE_NS / `LSDPM_CLK_NS)
`define LSDPM_PUMP_HZ     800000
`define LSDPM_CLK_HZ      25000000
// Rounded to the nearest whole cycle, not truncated
`define LSDPM_HALF_CYC    ((`LSDPM_CLK_HZ + `LSDPM_PUMP_HZ) / (2 * `LSDPM_PUMP_HZ))
`define LSDPM_NOVL_CYC    1
`endif

// ### src/lsdpm_pkg.sv
// Types for the strobe dimming and pump mode controller.
// Assumes the constants header is compiled alongside.
package lsdpm_pkg;
  typedef enum logic [2:0] {
    LSDPM_X1  = 3'h1,
    LSDPM_X15 = 3'h2,
    LSDPM_X2  = 3'h4
  } lsdpm_mode_type;
endpackage

// ### src/lsdpm_top.sv
// Strobe-programmed LED DAC codes and charge pump mode sequencer.
// Assumes strobe and dropout inputs synchronous to CLK_SYS.
`timescale 1ns/10ps
`include "lsdpm_defs.svh"
module lsdpm_top #(
  parameter int SETTLE_CYC = `LSDPM_SETTLE_CYC,
  parameter int BGAP_CYC   = `LSDPM_BGAP_CYC,
  parameter int MODE_CYC   = `LSDPM_MODE_CYC,
  parameter int MW         = 5,
  parameter int CW         = 3
) (
  input  wire logic          CLK_SYS,
  input  wire logic          SYS_RST,
  input  wire logic          MAIN_STROBE_IN,
  input  wire logic          CAM_STROBE_IN,
  input  wire logic          DROPOUT,
  output logic [MW-1:0]      MAIN_LED_OUT_A,
  output logic [MW-1:0]      MAIN_LED_OUT_B,
  output logic [MW-1:0]      MAIN_LED_OUT_C,
  output logic [MW-1:0]      MAIN_LED_OUT_D,
  output logic [CW-1:0]      CAM_LED_OUT,
  output logic               SHUTDOWN,
  output logic [2:0]         PUMP_MODE,
  output logic               PUMP_PH1,
  output logic               PUMP_PH2,
  output logic               SW_SERIES_CHG,
  output logic               SW_PARALLEL_DIS,
  output logic               SW_CAP1_CHG,
  output logic               SW_CAP2_CHG,
  output logic               PUMP_OUTPUT_EN
);
  // ****************************************
  // Strobe history and shared timers
  // ****************************************
  logic          m_d;
  logic          c_d;
  logic          next_m_d;
  logic          next_c_d;
  logic [31:0]   m_tmr;
  logic [31:0]   c_tmr;
  logic [31:0]   s_tmr;
  logic [31:0]   next_m_tmr;
  logic [31:0]   next_c_tmr;
  logic [31:0]   next_s_tmr;
  logic          sd;
  logic          next_sd;
  logic          bgap;
  logic          next_bgap;
  logic [MW-1:0] m_cnt;
  logic [MW-1:0] next_m_cnt;
  logic [MW-1:0] m_dac;
  logic [MW-1:0] next_m_dac;
  logic [CW-1:0] c_cnt;
  logic [CW-1:0] next_c_cnt;
  logic [CW-1:0] c_dac;
  logic [CW-1:0] next_c_dac;
  logic          m_rise;
  logic          c_rise;
  logic          m_edge;
  logic          c_edge;
  logic          c_fall;
  logic          m_done;
  logic          c_done;
  logic          s_done;
  logic [31:0]   en_lim;

  assign m_rise = MAIN_STROBE_IN & ~m_d;
  assign c_rise = CAM_STROBE_IN & ~c_d;
  assign c_fall = ~CAM_STROBE_IN & c_d;
  assign m_edge = MAIN_STROBE_IN ^ m_d;
  assign c_edge = CAM_STROBE_IN ^ c_d;
  // Wake from shutdown waits for the reference too
  assign en_lim = bgap ? 32'(SETTLE_CYC + BGAP_CYC) : 32'(SETTLE_CYC); // RL10
  assign m_done = m_tmr >= 32'(SETTLE_CYC);
  assign c_done = c_tmr >= 32'(SETTLE_CYC);
  assign s_done = s_tmr >= 32'(SETTLE_CYC);

  always_comb begin
    next_m_d   = MAIN_STROBE_IN;
    next_c_d   = CAM_STROBE_IN;
    // Timers restart on any edge and saturate, so no wrap can fake a delay
    if (m_edge) begin
      next_m_tmr = 32'h0; // RL20
    end else if (m_tmr >= en_lim) begin
      next_m_tmr = m_tmr;
    end else begin
      next_m_tmr = m_tmr + 32'h1; // RL20
    end
    if (c_edge) begin
      next_c_tmr = 32'h0; // RL20
    end else if (c_tmr >= en_lim) begin
      next_c_tmr = c_tmr;
    end else begin
      next_c_tmr = c_tmr + 32'h1; // RL20
    end
    if (MAIN_STROBE_IN || CAM_STROBE_IN) begin
      next_s_tmr = 32'h0; // RL20
    end else if (s_done) begin
      next_s_tmr = s_tmr;
    end else begin
      next_s_tmr = s_tmr + 32'h1;
    end
    next_sd    = sd;
    next_bgap  = bgap;
    if (!MAIN_STROBE_IN && !CAM_STROBE_IN && s_done) begin
      next_sd   = 1'b1; // RL9
      next_bgap = 1'b1; // RL10
    end else if (MAIN_STROBE_IN || CAM_STROBE_IN) begin
      next_sd = 1'b0;
    end
    if (bgap && ((MAIN_STROBE_IN && m_tmr >= en_lim) || (CAM_STROBE_IN && c_tmr >= en_lim)))
      next_bgap = 1'b0;
  end

  // ****************************************
  // Main counter and DAC holding register
  // ****************************************
  always_comb begin
    next_m_cnt = m_cnt;
    next_m_dac = m_dac;
    // Count 0 means cleared; first edge wraps to full scale
    if (m_rise && m_cnt != {{(MW-1){1'b0}}, 1'b1}) // RL3
      next_m_cnt = m_cnt - 1'b1; // RL1 RL4
    if (!MAIN_STROBE_IN) begin
      next_m_dac = '0; // RL7
      if (m_done)
        next_m_cnt = '0; // RL8
    end else if (m_tmr >= en_lim && !m_edge) begin
      next_m_dac = m_cnt; // RL6 RL21
    end
  end

  // ****************************************
  // Camera counter and DAC holding register
  // ****************************************
  always_comb begin
    next_c_cnt = c_cnt;
    next_c_dac = c_dac;
    if (c_rise && c_cnt != {{(CW-1){1'b0}}, 1'b1}) // RL3
      next_c_cnt = c_cnt - 1'b1; // RL2 RL4
    if (!CAM_STROBE_IN) begin
      next_c_dac = '0; // RL7
      if (c_done)
        next_c_cnt = '0; // RL8
    end else if (c_tmr >= en_lim && !c_edge) begin
      next_c_dac = c_cnt; // RL6 RL21
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      m_d   <= 1'b0;
      c_d   <= 1'b0;
      m_tmr <= 32'h0;
      c_tmr <= 32'h0;
      s_tmr <= 32'h0;
      sd    <= 1'b1;
      bgap  <= 1'b1;
      m_cnt <= '0;
      c_cnt <= '0;
      m_dac <= '0;
      c_dac <= '0;
    end else begin
      m_d   <= next_m_d;
      c_d   <= next_c_d;
      m_tmr <= next_m_tmr;
      c_tmr <= next_c_tmr;
      s_tmr <= next_s_tmr;
      sd    <= next_sd;
      bgap  <= next_bgap;
      m_cnt <= next_m_cnt;
      c_cnt <= next_c_cnt;
      m_dac <= next_m_dac;
      c_dac <= next_c_dac;
    end
  end

  // ****************************************
  // Pump mode sequencer
  // ****************************************
  lsdpm_pkg::lsdpm_mode_type mode;
  lsdpm_pkg::lsdpm_mode_type next_mode;
  logic [31:0]               dly;
  logic [31:0]               next_dly;

  always_comb begin
    next_mode = mode;
    if (DROPOUT) begin
      next_dly = dly + 32'h1;
    end else begin
      next_dly = 32'h0;
    end
    if (sd || next_sd || c_fall) begin
      next_mode = lsdpm_pkg::LSDPM_X1; // RL11 RL13
      next_dly  = 32'h0;
    end else if (DROPOUT && dly >= 32'(MODE_CYC - 1)) begin // RL18
      next_dly = 32'h0;
      case (mode)
        lsdpm_pkg::LSDPM_X1:  next_mode = lsdpm_pkg::LSDPM_X15; // RL12
        lsdpm_pkg::LSDPM_X15: next_mode = lsdpm_pkg::LSDPM_X2;  // RL12
        lsdpm_pkg::LSDPM_X2:  next_mode = lsdpm_pkg::LSDPM_X2;
        default:              next_mode = lsdpm_pkg::LSDPM_X1;
      endcase
    end
  end

  // ****************************************
  // Two-phase non-overlapping clock
  // ****************************************
  // Half period of 16 cycles gives 781 kHz; the nearest whole count at 25 MHz
  logic [7:0] ph_cnt;
  logic [7:0] next_ph_cnt;
  logic       ph;
  logic       next_ph;
  logic       p1;
  logic       p2;

  always_comb begin
    next_ph_cnt = ph_cnt + 8'h1;
    next_ph     = ph;
    if (ph_cnt >= 8'(`LSDPM_HALF_CYC - 1)) begin // RL14
      next_ph_cnt = 8'h0;
      next_ph     = ~ph;
    end
    p1 = 1'b0;
    p2 = 1'b0;
    // Dead time at each half start keeps both phases from overlapping
    if (!sd && ph_cnt >= 8'(`LSDPM_NOVL_CYC)) begin
      p1 = ~ph; // RL14
      p2 = ph;  // RL14
    end
  end

  // ****************************************
  // Switch drive decode
  // ****************************************
  logic next_ser;
  logic next_par;
  logic next_cap1;
  logic next_cap2;

  always_comb begin
    next_ser  = 1'b0;
    next_par  = 1'b0;
    next_cap1 = 1'b0;
    next_cap2 = 1'b0;
    case (mode)
      lsdpm_pkg::LSDPM_X15: begin
        next_ser = p1; // RL16
        next_par = p2; // RL16
      end
      lsdpm_pkg::LSDPM_X2: begin
        next_cap1 = p1; // RL15
        next_cap2 = p2; // RL15
      end
      default: begin
        next_ser = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode   <= lsdpm_pkg::LSDPM_X1;
      dly    <= 32'h0;
      ph_cnt <= 8'h0;
      ph     <= 1'b0;
    end else begin
      mode   <= next_mode;
      dly    <= next_dly;
      ph_cnt <= next_ph_cnt;
      ph     <= next_ph;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      MAIN_LED_OUT_A  <= '0;
      MAIN_LED_OUT_B  <= '0;
      MAIN_LED_OUT_C  <= '0;
      MAIN_LED_OUT_D  <= '0;
      CAM_LED_OUT     <= '0;
      SHUTDOWN        <= 1'b1;
      PUMP_MODE       <= 3'h1;
      PUMP_PH1        <= 1'b0;
      PUMP_PH2        <= 1'b0;
      SW_SERIES_CHG   <= 1'b0;
      SW_PARALLEL_DIS <= 1'b0;
      SW_CAP1_CHG     <= 1'b0;
      SW_CAP2_CHG     <= 1'b0;
      PUMP_OUTPUT_EN  <= 1'b0;
    end else begin
      MAIN_LED_OUT_A  <= next_m_dac;
      MAIN_LED_OUT_B  <= next_m_dac;
      MAIN_LED_OUT_C  <= next_m_dac;
      MAIN_LED_OUT_D  <= next_m_dac; // RL17
      CAM_LED_OUT     <= next_c_dac;
      SHUTDOWN        <= next_sd; // RL9
      PUMP_MODE       <= next_mode;
      PUMP_PH1        <= p1;
      PUMP_PH2        <= p2;
      SW_SERIES_CHG   <= next_ser;  // RL16
      SW_PARALLEL_DIS <= next_par;  // RL16
      SW_CAP1_CHG     <= next_cap1; // RL15
      SW_CAP2_CHG     <= next_cap2; // RL15
      PUMP_OUTPUT_EN  <= ~next_sd;
    end
  end
endmodule

// ### test/lsdpm_assertions.sv
// Port checker for lsdpm_top.
// Assumes one clock domain, bound into every lsdpm_top.
`timescale 1ns/10ps
module lsdpm_assertions #(
  parameter int MW = 5,
  parameter int CW = 3
) (
  input wire logic          CLK_SYS,
  input wire logic          SYS_RST,
  input wire logic          MAIN_STROBE_IN,
  input wire logic          CAM_STROBE_IN,
  input wire logic [MW-1:0] MAIN_LED_OUT_A,
  input wire logic [MW-1:0] MAIN_LED_OUT_B,
  input wire logic [MW-1:0] MAIN_LED_OUT_C,
  input wire logic [MW-1:0] MAIN_LED_OUT_D,
  input wire logic [CW-1:0] CAM_LED_OUT,
  input wire logic          SHUTDOWN,
  input wire logic [2:0]    PUMP_MODE,
  input wire logic          PUMP_PH1,
  input wire logic          PUMP_PH2,
  input wire logic          PUMP_OUTPUT_EN,
  input wire logic          SW_SERIES_CHG,
  input wire logic          SW_PARALLEL_DIS,
  input wire logic          SW_CAP1_CHG,
  input wire logic          SW_CAP2_CHG
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // ****
  // Pump mode steps, shutdown, main and camera output codes, and switch drive
  // ****
  sequence s_step;
    $changed(PUMP_MODE) && PUMP_MODE != 3'h1;
  endsequence
  a_mode_step: assert property (s_step |-> PUMP_MODE == ($past(PUMP_MODE) << 1))
    else $error("mode skipped a step");
  a_cam_fall: assert property ($fell(CAM_STROBE_IN) |-> ##[1:2] PUMP_MODE == 3'h1)
    else $error("mode kept after camera fall");
  a_shut_mode: assert property (SHUTDOWN |=> PUMP_MODE == 3'h1)
    else $error("mode kept in shutdown");
  // Two samples, since shutdown and phases are both registered
  a_shut_quiet: assert property (SHUTDOWN[*2] |-> !PUMP_PH1 && !PUMP_PH2 && !PUMP_OUTPUT_EN)
    else $error("pump active in shutdown");
  a_phase_gap: assert property (!(PUMP_PH1 && PUMP_PH2))
    else $error("pump phases overlap");
  a_main_track: assert property (MAIN_LED_OUT_D == MAIN_LED_OUT_A)
    else $error("fourth main output differs");
  a_main_clear: assert property (!MAIN_STROBE_IN[*2] |-> MAIN_LED_OUT_A == '0)
    else $error("main code kept while low");
  a_cam_clear: assert property (!CAM_STROBE_IN[*2] |-> CAM_LED_OUT == '0)
    else $error("camera code kept while low");
  a_main_copies: assert property (MAIN_LED_OUT_B == MAIN_LED_OUT_A && MAIN_LED_OUT_C == MAIN_LED_OUT_A)
    else $error("main outputs differ");
  // Switches follow the mode held one sample earlier than the phase
  a_series_drive: assert property (SW_SERIES_CHG == (PUMP_PH1 && $past(PUMP_MODE) == 3'h2))
    else $error("series charge switch wrong");
  a_parallel_drive: assert property (SW_PARALLEL_DIS == (PUMP_PH2 && $past(PUMP_MODE) == 3'h2))
    else $error("parallel stack switch wrong");
  a_cap1_drive: assert property (SW_CAP1_CHG == (PUMP_PH1 && $past(PUMP_MODE) == 3'h4))
    else $error("first capacitor switch wrong");
  a_cap2_drive: assert property (SW_CAP2_CHG == (PUMP_PH2 && $past(PUMP_MODE) == 3'h4))
    else $error("second capacitor switch wrong");
endmodule
bind lsdpm_top lsdpm_assertions #(.MW(MW), .CW(CW)) i_chk (.*);

// ### test/lsdpm_host.sv
// Host model driving the two strobe pins.
// Assumes callers run its tasks from a clocked sequence.
`timescale 1ns/10ps
module lsdpm_host (
  input  wire logic clk,
  output logic      main_stb,
  output logic      cam_stb
);
  initial begin
    main_stb = 1'b0;
    cam_stb  = 1'b0;
  end
  // Each level stands 5 cycles, the shortest legal pulse
  task automatic set(input logic cam, input logic v);
    repeat (5) @(posedge clk);
    #2;
    if (cam)
      cam_stb = v;
    else
      main_stb = v;
  endtask
  // Left high afterwards so the count is taken
  task automatic pulse(input logic cam, input int n);
    repeat (n) begin
      set(cam, 1'b0);
      set(cam, 1'b1);
    end
  endtask
endmodule

// ### test/tb_lsdpm_top.sv
// Self-checking bench for lsdpm_top.
// Assumes lsdpm_host and the bound checker are compiled.
`timescale 1ns/10ps
module tb_lsdpm_top;
  localparam int ST = 20;
  localparam int BG = 10;
  localparam int MC = 30;
  logic        clk_sys;
  logic        sys_rst;
  logic        dropout;
  logic        m_stb;
  logic        c_stb;
  logic [4:0]  led_a;
  logic [4:0]  led_d;
  logic [2:0]  led_c;
  logic        shut;
  logic [2:0]  mode;
  logic [31:0] seed;
  int          err_total;
  int          num_checks;
  int          nm;
  int          nc;
  int          tm[4] = '{1, 31, 32, 5};
  int          tc[4] = '{7, 8, 1, 3};
  lsdpm_host i_host (.clk(clk_sys), .main_stb(m_stb), .cam_stb(c_stb));
  lsdpm_top #(.SETTLE_CYC(ST), .BGAP_CYC(BG), .MODE_CYC(MC)) i_dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .MAIN_STROBE_IN(m_stb), .CAM_STROBE_IN(c_stb),
    .DROPOUT(dropout), .MAIN_LED_OUT_A(led_a), .MAIN_LED_OUT_B(), .MAIN_LED_OUT_C(),
    .MAIN_LED_OUT_D(led_d), .CAM_LED_OUT(led_c), .SHUTDOWN(shut), .PUMP_MODE(mode),
    .PUMP_PH1(), .PUMP_PH2(), .SW_SERIES_CHG(), .SW_PARALLEL_DIS(), .SW_CAP1_CHG(),
    .SW_CAP2_CHG(), .PUMP_OUTPUT_EN());
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [4:0] exp_code(input int n, input int w);
    return 5'((n < (1 << w)) ? (1 << w) - n : 1);
  endfunction
  task automatic check(input string what, input logic [4:0] exp, input logic [4:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Far longer than the whole sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    give_verdict();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    err_total = 0;
    num_checks = 0;
    seed = 32'h17cce;
    sys_rst = 1'b1;
    dropout = 1'b0;
    settle(8);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      nm = (i < 4) ? tm[i] : int'(seed[7:0]) % 40 + 1;
      nc = (i < 4) ? tc[i] : int'(seed[15:8]) % 10 + 1;
      check("shutdown", 5'h1, {4'h0, shut});
      check("mode", 5'h1, {2'h0, mode});
      i_host.pulse(1'b0, nm);
      i_host.pulse(1'b1, nc);
      settle(ST + BG + 4);
      check("main", exp_code(nm, 5), led_a);
      check("main_d", exp_code(nm, 5), led_d);
      check("cam", exp_code(nc, 3), {2'h0, led_c});
      i_host.set(1'b0, 1'b0);
      i_host.set(1'b1, 1'b0);
      check("main_off", 5'h0, led_a);
      settle(ST + 4);
      check("cam_off", 5'h0, {2'h0, led_c});
      $display("strobe test %0d done", i);
    end
    i_host.pulse(1'b1, 1);
    i_host.pulse(1'b0, 3);
    i_host.set(1'b0, 1'b0);
    i_host.pulse(1'b0, 2);
    settle(ST + BG + 4);
    check("resume", 5'h1b, led_a);
    i_host.set(1'b0, 1'b0);
    settle(ST + 4);
    i_host.pulse(1'b0, 1);
    settle(ST + 4);
    check("restart", 5'h1f, led_a);
    $display("retention test done");
    dropout = 1'b1;
    settle(MC - 3);
    check("mode_wait", 5'h1, {2'h0, mode});
    settle(6);
    check("mode_15", 5'h2, {2'h0, mode});
    settle(MC);
    check("mode_2", 5'h4, {2'h0, mode});
    dropout = 1'b0;
    i_host.set(1'b1, 1'b0);
    settle(2);
    check("mode_back", 5'h1, {2'h0, mode});
    $display("pump mode test done");
    give_verdict();
  end
endmodule
